// ---- rtl/opamp_ctrl.sv ----
// AXI4-Lite register bank controlling two measurement amplifiers and their pin switches
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`include "opamp_ctrl_params.svh"
module opamp_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [5:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic amp_a_out_level,
	input wire logic amp_b_out_level,
	output opamp_ctrl_pkg::amp_ctrl_s amp_a_ctrl,
	output opamp_ctrl_pkg::amp_ctrl_s amp_b_ctrl,
	output opamp_ctrl_pkg::pin_sw_s pin_sw
);
	import opamp_ctrl_pkg::*;

	logic awready_r;
	logic wready_r;
	logic aw_have_r;
	logic w_have_r;
	logic [5:0] aw_addr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [5:0] ar_addr_r;
	amp_ctrl_s amp_a_r;
	amp_ctrl_s amp_b_r;
	amp_ctrl_s amp_a_nxt;
	amp_ctrl_s amp_b_nxt;
	pin_sw_s sw_r;
	pin_sw_s sw_nxt;
	logic amp_a_status;
	logic amp_b_status;

	////////////////////////////////////////////////////////////////////////////
	// Live status of both amplifiers
	status_gate u_gate_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(amp_a_out_level),
		.amp_on(amp_a_r.on),
		.cal_mode(amp_a_r.cal_mode),
		.status(amp_a_status)
	);
	status_gate u_gate_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(amp_b_out_level),
		.amp_on(amp_b_r.on),
		.cal_mode(amp_b_r.cal_mode),
		.status(amp_b_status)
	);

	////////////////////////////////////////////////////////////////////////////
	// Write address decode
	logic aw_take;
	logic w_take;
	logic wr_go;
	logic [3:0] wr_widx;
	logic wr_hit_a;
	logic wr_hit_b;
	logic wr_hit_fixed;
	logic wr_hit_lo;
	logic wr_hit_hi;
	logic wr_ok;
	logic wr_en;
	logic [2:0] wr_lo_j;
	logic [2:0] wr_hi_j;
	assign aw_take = awvalid & awready_r;
	assign w_take = wvalid & wready_r;
	assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_widx = aw_addr_r[5:2];
	assign wr_hit_a = aw_addr_r == `OFS_AMP_A;
	assign wr_hit_b = aw_addr_r == `OFS_AMP_B;
	assign wr_hit_fixed = (aw_addr_r == `OFS_REF_STAT) | (aw_addr_r == `OFS_AMP_C);
	assign wr_hit_lo = (wr_widx >= `WIDX_PIN_LO_FIRST) & (wr_widx <= `WIDX_PIN_LO_LAST)
		& (aw_addr_r[1:0] == 2'h0);
	assign wr_hit_hi = (wr_widx >= `WIDX_PIN_HI_FIRST) & (wr_widx <= `WIDX_PIN_HI_LAST)
		& (aw_addr_r[1:0] == 2'h0);
	assign wr_ok = wr_hit_a | wr_hit_b | wr_hit_fixed | wr_hit_lo | wr_hit_hi;
	assign wr_en = wr_go & wlane_r;
	assign wr_lo_j = 3'(wr_widx - `WIDX_PIN_LO_FIRST);
	assign wr_hi_j = 3'(wr_widx - `WIDX_PIN_HI_FIRST);

	// Amplifier control next values; the whole byte maps onto the fields
	assign amp_a_nxt = (wr_en & wr_hit_a) ? amp_ctrl_s'(wbyte_r) : amp_a_r;
	assign amp_b_nxt = (wr_en & wr_hit_b) ? amp_ctrl_s'(wbyte_r) : amp_b_r;

	// Pin switch next values; bits outside this block are dropped
	always_comb begin
		sw_nxt = sw_r;
		if (wr_en & wr_hit_lo) begin
			sw_nxt.amp_b_neg[wr_lo_j] = wbyte_r[`BIT_LO_BNEG];
			sw_nxt.amp_a_neg[wr_lo_j] = wbyte_r[`BIT_LO_ANEG];
		end
		if (wr_en & wr_hit_hi) begin
			sw_nxt.amp_b_pos[wr_hi_j] = wbyte_r[`BIT_HI_BPOS];
			sw_nxt.amp_b_out[wr_hi_j] = wbyte_r[`BIT_HI_BOUT];
			sw_nxt.amp_a_pos[wr_hi_j] = wbyte_r[`BIT_HI_APOS];
			sw_nxt.amp_a_out[wr_hi_j] = wbyte_r[`BIT_HI_AOUT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write channels: address and data accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			aw_have_r <= 1'b0;
			aw_addr_r <= 6'h00;
		end else begin
			awready_r <= awvalid & ~awready_r & ~aw_have_r & ~bvalid_r;
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= awaddr;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b0;
			w_have_r <= 1'b0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else begin
			wready_r <= wvalid & ~wready_r & ~w_have_r & ~bvalid_r;
			if (w_take) begin
				w_have_r <= 1'b1;
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// Write response after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Stored controls, updated at the commit edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_a_r <= `AMP_RST;
			amp_b_r <= `AMP_RST;
			sw_r <= {6{`SW_GROUP_RST}};
		end else begin
			amp_a_r <= amp_a_nxt;
			amp_b_r <= amp_b_nxt;
			sw_r <= sw_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read address decode
	logic ar_take;
	logic [3:0] rd_widx;
	logic rd_hit_lo;
	logic rd_hit_hi;
	logic rd_ok;
	logic [2:0] rd_lo_j;
	logic [2:0] rd_hi_j;
	logic [7:0] rd_byte;
	assign ar_take = arvalid & arready_r;
	assign rd_widx = araddr[5:2];
	assign rd_hit_lo = (rd_widx >= `WIDX_PIN_LO_FIRST) & (rd_widx <= `WIDX_PIN_LO_LAST)
		& (araddr[1:0] == 2'h0);
	assign rd_hit_hi = (rd_widx >= `WIDX_PIN_HI_FIRST) & (rd_widx <= `WIDX_PIN_HI_LAST)
		& (araddr[1:0] == 2'h0);
	assign rd_lo_j = 3'(rd_widx - `WIDX_PIN_LO_FIRST);
	assign rd_hi_j = 3'(rd_widx - `WIDX_PIN_HI_FIRST);

	// Read byte: unimplemented positions stay zero
	always_comb begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		if (araddr == `OFS_REF_STAT) begin
			rd_byte[`BIT_A_STAT] = amp_a_status;
		end else if (araddr == `OFS_AMP_A) begin
			rd_byte = amp_a_r;
		end else if (araddr == `OFS_AMP_B) begin
			rd_byte = amp_b_r;
		end else if (araddr == `OFS_AMP_C) begin
			rd_byte[`BIT_B_STAT] = amp_b_status;
		end else if (rd_hit_lo) begin
			rd_byte[`BIT_LO_BNEG] = sw_r.amp_b_neg[rd_lo_j];
			rd_byte[`BIT_LO_ANEG] = sw_r.amp_a_neg[rd_lo_j];
		end else if (rd_hit_hi) begin
			rd_byte[`BIT_HI_BPOS] = sw_r.amp_b_pos[rd_hi_j];
			rd_byte[`BIT_HI_BOUT] = sw_r.amp_b_out[rd_hi_j];
			rd_byte[`BIT_HI_APOS] = sw_r.amp_a_pos[rd_hi_j];
			rd_byte[`BIT_HI_AOUT] = sw_r.amp_a_out[rd_hi_j];
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read channel: one read at a time, data sampled at address accept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
			ar_addr_r <= 6'h00;
		end else begin
			arready_r <= arvalid & ~arready_r & ~rvalid_r;
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r <= {24'h000000, rd_byte};
				rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
				ar_addr_r <= araddr;
			end else if (rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Port drivers, all straight from flops
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign amp_a_ctrl = amp_a_r;
	assign amp_b_ctrl = amp_b_r;
	assign pin_sw = sw_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_cal_mode;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && wr_hit_a) |=> amp_a_ctrl.cal_mode == $past(wbyte_r[`BIT_CAL]);
	endproperty
	a_cal_mode: assert property (p_cal_mode) else $error("mode bit not stored");
	property p_ref_select;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && wr_hit_b) |=> amp_b_ctrl.ref_select == $past(wbyte_r[`BIT_REFSEL]);
	endproperty
	a_ref_select: assert property (p_ref_select) else $error("ref select wrong");
	property p_enable;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && wr_hit_a) |=> amp_a_ctrl.on == $past(wbyte_r[`BIT_ON]);
	endproperty
	a_enable: assert property (p_enable) else $error("enable bit wrong");
	property p_trim_hold;
		@(posedge aclk) disable iff (!aresetn)
		!(wr_en && wr_hit_b) |=> $stable(amp_b_ctrl.trim);
	endproperty
	a_trim_hold: assert property (p_trim_hold) else $error("trim changed unwritten");
	property p_pin_lo;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && wr_hit_lo) |=> pin_sw.amp_a_neg[$past(wr_lo_j)] == $past(wbyte_r[1]);
	endproperty
	a_pin_lo: assert property (p_pin_lo) else $error("low pin switch wrong");
	property p_pin_hi;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && wr_hit_hi) |=> pin_sw.amp_b_pos[$past(wr_hi_j)] == $past(wbyte_r[3]);
	endproperty
	a_pin_hi: assert property (p_pin_hi) else $error("high pin switch wrong");
	property p_upper_zero;
		@(posedge aclk) disable iff (!aresetn)
		rvalid && (ar_addr_r == `OFS_AMP_C) |-> rdata[31:6] == 26'h0 && rdata[4:0] == 5'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("unused bits nonzero");
	property p_wr_resp;
		@(posedge aclk) disable iff (!aresetn) wr_go |=> bvalid ##0 !aw_have_r;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_rd_resp;
		@(posedge aclk) disable iff (!aresetn) $rose(arvalid) && !rvalid |-> ##[1:2] rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read response late");
	property p_cov_cal;
		@(posedge aclk) disable iff (!aresetn) amp_a_ctrl.cal_mode && amp_a_ctrl.ref_select;
	endproperty
	c_cov_cal: cover property (p_cov_cal);
	property p_cov_err;
		@(posedge aclk) disable iff (!aresetn) bvalid && bresp == `RESP_SLVERR;
	endproperty
	c_cov_err: cover property (p_cov_err);
	property p_cov_sw;
		@(posedge aclk) disable iff (!aresetn) |pin_sw.amp_a_out;
	endproperty
	c_cov_sw: cover property (p_cov_sw);
endmodule

// ---- rtl/opamp_ctrl_params.svh ----
// Offsets, bit positions, reset values and bus codes of the amplifier control bank
`ifndef OPAMP_CTRL_PARAMS_SVH
`define OPAMP_CTRL_PARAMS_SVH
`define OFS_REF_STAT 6'h00
`define OFS_AMP_A 6'h04
`define OFS_AMP_B 6'h08
`define OFS_AMP_C 6'h0c
`define WIDX_PIN_LO_FIRST 4'h4
`define WIDX_PIN_LO_LAST 4'h8
`define WIDX_PIN_HI_FIRST 4'h9
`define WIDX_PIN_HI_LAST 4'hd
`define BIT_CAL 7
`define BIT_REFSEL 6
`define BIT_ON 5
`define TRIM_MSB 4
`define BIT_A_STAT 7
`define BIT_B_STAT 5
`define BIT_LO_BNEG 2
`define BIT_LO_ANEG 1
`define BIT_HI_BPOS 3
`define BIT_HI_BOUT 2
`define BIT_HI_APOS 1
`define BIT_HI_AOUT 0
`define AMP_RST 8'h00
`define SW_GROUP_RST 5'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- rtl/opamp_ctrl_pkg.sv ----
// Types shared by the amplifier control bank
package opamp_ctrl_pkg;
	// One amplifier's control fields, top bit first as in its register
	typedef struct packed {
		logic cal_mode;
		logic ref_select;
		logic on;
		logic [4:0] trim;
	} amp_ctrl_s;
	// Pin switch closures, one bit per analog pin of the group
	typedef struct packed {
		logic [4:0] amp_b_neg;
		logic [4:0] amp_a_neg;
		logic [4:0] amp_b_pos;
		logic [4:0] amp_b_out;
		logic [4:0] amp_a_pos;
		logic [4:0] amp_a_out;
	} pin_sw_s;
endpackage

// ---- rtl/status_gate.sv ----
// Synchroniser and enable gate for one amplifier's digital output status
module status_gate (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic level_in,
	input wire logic amp_on,
	input wire logic cal_mode,
	output logic status
);
	logic sync1_r;
	logic sync2_r;
	logic status_r;

	// Two flops before anything looks at the comparator level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= level_in;
			sync2_r <= sync1_r;
		end
	end

	// Positive logic, forced low while the amplifier is off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= 1'b0;
		end else begin
			status_r <= amp_on & sync2_r;
		end
	end
	assign status = status_r;

	////////////////////////////////////////////////////////////////////////////
	property p_off_zero;
		@(posedge aclk) disable iff (!aresetn) !amp_on |=> !status_r;
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("status set while amp off");
	property p_cal_follow;
		@(posedge aclk) disable iff (!aresetn)
		(amp_on && cal_mode) |=> status_r == $past(sync2_r);
	endproperty
	a_cal_follow: assert property (p_cal_follow) else $error("status not following");
	property p_polarity;
		@(posedge aclk) disable iff (!aresetn) (amp_on && level_in)[*4] |-> status_r;
	endproperty
	a_polarity: assert property (p_polarity) else $error("status not positive logic");
	property p_cov_toggle;
		@(posedge aclk) disable iff (!aresetn) cal_mode && $rose(status_r);
	endproperty
	c_cov_toggle: cover property (p_cov_toggle);
endmodule

// ---- verif/tb_opamp_ctrl.sv ----
// Self-checking bench for the amplifier control register bank
`include "opamp_ctrl_params.svh"
`define CHK(what, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("BAD %s expected %h seen %h", what, exp, got); \
	end \
end
module tb_opamp_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import opamp_ctrl_pkg::*;
	localparam int TH = 13;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, lvl_a, lvl_b;
	logic [5:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	amp_ctrl_s amp_a_ctrl, amp_b_ctrl;
	pin_sw_s pin_sw;
	int num_errors = 0;
	int comparisons = 0;
	opamp_ctrl u_opamp_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.amp_a_out_level(lvl_a), .amp_b_out_level(lvl_b), .amp_a_ctrl(amp_a_ctrl),
		.amp_b_ctrl(amp_b_ctrl), .pin_sw(pin_sw));
	// Free running 10 MHz clock
	always #50 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic hang;
		num_errors++;
		$display("BAD handshake expected answer seen none");
		finish_test();
	endtask
	// Write one byte; address and data offered together, each dropped when taken
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		logic aw_ok, w_ok, b_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !b_ok; n++) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
			if (aw_ok && w_ok && bvalid === 1'b1) begin
				b_ok = 1'b1;
				r = bresp;
				bready <= 1'b0;
			end
		end
		if (!b_ok) hang();
	endtask
	// Read one word; rready held until the answer is sampled
	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ok;
		ok = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				ok = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
		if (!ok) hang();
	endtask
	task automatic wchk(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		logic [1:0] r;
		wr(a, d, 4'h1, r);
		`CHK("bresp", er, r)
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK("rdata", e, d)
		`CHK("rresp", er, r)
	endtask
	// Amplifier output level change, then settle through the status pipeline
	task automatic lvl(input bit sel, input logic v);
		@(posedge aclk);
		if (sel) lvl_b <= v;
		else lvl_a <= v;
		repeat (5) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 14; i++) rchk(6'(4 * i), 32'h0, `RESP_OKAY);
		`CHK("pin_sw", 30'h0, pin_sw)
		$display("test reset done");
	endtask
	task automatic t_fields;
		// Calibration mode is only ever set together with positive reference select
		logic [7:0] v[6] = '{8'hc0, 8'h2a, 8'h20, 8'h1f, 8'h15, 8'h00};
		for (int i = 0; i < 6; i++) begin
			wchk(`OFS_AMP_A, v[i], `RESP_OKAY);
			wchk(`OFS_AMP_B, ~v[i], `RESP_OKAY);
			rchk(`OFS_AMP_A, {24'h0, v[i]}, `RESP_OKAY);
			rchk(`OFS_AMP_B, {24'h0, ~v[i]}, `RESP_OKAY);
			`CHK("amp_a_ctrl", v[i], amp_a_ctrl)
			`CHK("amp_b_ctrl", ~v[i], amp_b_ctrl)
		end
		$display("test fields done");
	endtask
	task automatic t_status(input logic [5:0] a, input logic [5:0] c, input bit sel,
		input logic [31:0] m);
		wchk(c, 8'hc0, `RESP_OKAY);
		lvl(sel, 1'b1);
		rchk(a, 32'h0, `RESP_OKAY);
		wchk(c, 8'he0, `RESP_OKAY);
		repeat (5) @(posedge aclk);
		rchk(a, m, `RESP_OKAY);
		wchk(a, 8'hff, `RESP_OKAY);
		rchk(a, m, `RESP_OKAY);
		lvl(sel, 1'b0);
		rchk(a, 32'h0, `RESP_OKAY);
		lvl(sel, 1'b1);
		wchk(c, 8'hc0, `RESP_OKAY);
		rchk(a, 32'h0, `RESP_OKAY);
		lvl(sel, 1'b0);
		wchk(c, 8'h00, `RESP_OKAY);
		$display("test status done");
	endtask
	task automatic t_pins;
		logic [7:0] w;
		logic [7:0] spare;
		logic [29:0] e;
		int k;
		for (int b = 0; b < 4; b++) begin
			e = 30'h0;
			for (int p = 0; p < 10; p++) begin
				// One switch per pin at a time; which one moves with pin and round
				k = (b + p) % 4;
				if (p < 5) begin
					w = 8'(2 << (k % 2));
					e[20 + 5 * (k % 2) + p] = 1'b1;
				end else begin
					w = 8'(1 << k);
					e[5 * k + p - 5] = 1'b1;
				end
				// Positions with no switch at all, set to show they are ignored
				spare = p < 5 ? 8'h01 : (p > 7 ? 8'hc0 : 8'h00);
				wchk(6'(16 + 4 * p), w | spare, `RESP_OKAY);
				rchk(6'(16 + 4 * p), {24'h0, w}, `RESP_OKAY);
			end
			`CHK("pin_sw", e, pin_sw)
		end
		$display("test pins done");
	endtask
	task automatic t_errors;
		logic [1:0] r;
		wchk(6'h38, 8'hff, `RESP_SLVERR);
		rchk(6'h38, 32'h0, `RESP_SLVERR);
		wchk(`OFS_AMP_A, 8'h21, `RESP_OKAY);
		wchk(6'h05, 8'hff, `RESP_SLVERR);
		wr(`OFS_AMP_A, 8'h3c, 4'h0, r);
		`CHK("bresp", `RESP_OKAY, r)
		rchk(`OFS_AMP_A, 32'h21, `RESP_OKAY);
		$display("test errors done");
	endtask
	// Step the trim until the status bit changes; the bench plays the comparator
	task automatic sweep(input int start, input int step, output int v);
		logic [31:0] d;
		logic [1:0] r;
		logic s0;
		v = -1;
		for (int t = start; t >= 0 && t < 32 && v < 0; t += step) begin
			wchk(`OFS_AMP_A, {3'b111, 5'(t)}, `RESP_OKAY);
			lvl(1'b0, t >= TH);
			rd(`OFS_REF_STAT, d, r);
			if (t == start) s0 = d[7];
			else if (d[7] !== s0) v = t;
		end
	endtask
	task automatic t_cal;
		int v1, v2;
		sweep(0, 1, v1);
		sweep(31, -1, v2);
		`CHK("up sweep", TH, v1)
		`CHK("down sweep", TH - 1, v2)
		wchk(`OFS_AMP_A, {3'b111, 5'((v1 + v2) / 2)}, `RESP_OKAY);
		`CHK("trim", 5'((2 * TH - 1) / 2), amp_a_ctrl.trim)
		lvl(1'b0, 1'b0);
		$display("test calibration done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, lvl_a, lvl_b} = 7'h00;
		{awaddr, araddr, awprot, arprot, wstrb} = 22'h0;
		wdata = 32'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_fields();
		t_status(`OFS_REF_STAT, `OFS_AMP_A, 1'b0, 32'h80);
		t_status(`OFS_AMP_C, `OFS_AMP_B, 1'b1, 32'h20);
		t_pins();
		t_errors();
		t_cal();
		finish_test();
	end
endmodule
